// ==== pkg/aidr_consts.vh ====
// constants for the analog input diagnostic record
`ifndef AIDR_CONSTS_VH
`define AIDR_CONSTS_VH

// access paths on the request port
`define AIDR_KIND_RSET 2'h0
`define AIDR_KIND_COIDX 2'h1
`define AIDR_KIND_ECSUB 2'h2

// record set numbers
`define AIDR_RSET_FULL 16'h0001
`define AIDR_RSET_HEAD 16'h0000
// fieldbus object indices
`define AIDR_COIDX_FULL 16'h2F01
`define AIDR_COIDX_HEAD 16'h2F00
`define AIDR_ECSUB_INDEX 16'h5005
// ethercat subindices
`define AIDR_ECSUB_FIRST 8'h02
`define AIDR_ECSUB_LASTB 8'h11
`define AIDR_ECSUB_STAMP 8'h13

// record byte positions and lengths
`define AIDR_REC_LEN 5'h14
`define AIDR_HEAD_LEN 5'h04
`define AIDR_STAMP_POS 5'h10
`define AIDR_STAMP_LEN 5'h04

// fixed byte values
`define AIDR_CLASS_RST 8'h15
`define AIDR_KIND_RST 8'h71
`define AIDR_BITS_RST 8'h08
`define AIDR_CHCNT_RST 8'h02

// summary byte fields
`define AIDR_SUM_MODFAIL 0
`define AIDR_SUM_INTERR 1
`define AIDR_SUM_EXTERR 2
`define AIDR_SUM_CHFLT 3
`define AIDR_SUM_AUX 4
`define AIDR_SUM_PARAM 7
// internal fault byte fields
`define AIDR_INT_BUFOVF 3
`define AIDR_INT_COMM 4
// channel byte fields
`define AIDR_CH_PARAM 0
`define AIDR_CH_WIRE 4
`define AIDR_CH_UNDER 6
`define AIDR_CH_OVER 7

// microsecond tick timing
`define AIDR_US_NS 1000
`define AIDR_CLK_NS 10
`define AIDR_US_CYC (`AIDR_US_NS / `AIDR_CLK_NS)

`endif

// ==== rtl/aidr_diag_record.v ====
// diagnostic record of a two-channel analog input module
`timescale 1ns/10ps
`include "aidr_consts.vh"

module aidr_diag_record #(
  parameter NUM_CH = 2,
  parameter US_CYC = `AIDR_US_CYC
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // module level fault conditions
  input wire module_fail,
  input wire internal_err,
  input wire external_err,
  input wire aux_supply_missing,
  input wire param_err,
  input wire diag_buf_overflow,
  input wire comm_err,
  // per channel fault conditions
  input wire [NUM_CH-1:0] ch_param_err,
  input wire [NUM_CH-1:0] ch_wire_break,
  input wire [NUM_CH-1:0] ch_underflow,
  input wire [NUM_CH-1:0] ch_overflow,
  // channel indicators
  output wire [NUM_CH-1:0] ch_led,
  // read request
  input wire req_valid,
  output wire req_ready,
  input wire [1:0] req_kind,
  input wire [15:0] req_number,
  input wire [7:0] req_subindex,
  // read answer
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  output reg rsp_last,
  output reg rsp_err
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;
  localparam NB = 20;

  reg state_r;
  reg [4:0] idx_r;
  reg [4:0] left_r;
  reg [NB*8-1:0] snap_r;
  reg [6:0] pre_r;
  reg [31:0] us_cnt_r;
  reg [31:0] stamp_r;
  reg [NUM_CH-1:0] led_r;
  reg [4*NUM_CH+6:0] flt_prev_r;
  wire [4*NUM_CH+6:0] flt_now;
  wire [NUM_CH-1:0] grp_err;
  wire [8*NUM_CH-1:0] ch_bytes;
  wire [7:0] sum_byte;
  wire [7:0] int_byte;
  wire [7:0] grp_byte;
  wire [NB*8-1:0] live;
  wire us_tick;
  wire new_flt;
  wire [7:0] sx_off;
  reg go;
  reg bad;
  reg [4:0] start;
  reg [4:0] len;

  // per channel error byte, group bit and indicator
  // channel bits are live levels; they clear when the input clears
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      assign ch_bytes[8*g+`AIDR_CH_PARAM] = ch_param_err[g];
      assign ch_bytes[8*g+3:8*g+1] = 3'h0;
      assign ch_bytes[8*g+`AIDR_CH_WIRE] = ch_wire_break[g];
      assign ch_bytes[8*g+5] = 1'b0;
      assign ch_bytes[8*g+`AIDR_CH_UNDER] = ch_underflow[g];
      assign ch_bytes[8*g+`AIDR_CH_OVER] = ch_overflow[g];
      assign grp_err[g] = |ch_bytes[8*g+7:8*g];
    end
  endgenerate

  // group byte, unused groups read zero
  assign grp_byte = {{(8-NUM_CH){1'b0}}, grp_err};

  // module fault summary byte
  assign sum_byte[`AIDR_SUM_MODFAIL] = module_fail;
  assign sum_byte[`AIDR_SUM_INTERR] =
    internal_err | diag_buf_overflow | comm_err;
  assign sum_byte[`AIDR_SUM_EXTERR] =
    external_err | aux_supply_missing;
  assign sum_byte[`AIDR_SUM_CHFLT] = |grp_err;
  assign sum_byte[`AIDR_SUM_AUX] = aux_supply_missing;
  assign sum_byte[6:5] = 2'h0;
  assign sum_byte[`AIDR_SUM_PARAM] =
    param_err | (|ch_param_err);

  // internal fault byte, only two flags are defined
  assign int_byte[2:0] = 3'h0;
  assign int_byte[`AIDR_INT_BUFOVF] = diag_buf_overflow;
  assign int_byte[`AIDR_INT_COMM] = comm_err;
  assign int_byte[7:5] = 3'h0;

  // whole record, byte 0 in the low lane, stamp most significant first
  assign live = {
    stamp_r[7:0], stamp_r[15:8], stamp_r[23:16], stamp_r[31:24],
    {(8*(8-NUM_CH)){1'b0}},
    ch_bytes,
    grp_byte,
    `AIDR_CHCNT_RST,
    `AIDR_BITS_RST,
    `AIDR_KIND_RST,
    int_byte,
    8'h00,
    `AIDR_CLASS_RST,
    sum_byte
  };

  // all fault sources, used to spot a new entry
  assign flt_now = {ch_param_err, ch_wire_break, ch_underflow,
    ch_overflow, module_fail, internal_err, external_err,
    aux_supply_missing, param_err, diag_buf_overflow, comm_err};

  // a fault input that was low last cycle and is high now
  assign new_flt = |(flt_now & ~flt_prev_r);

  // indicators follow channel errors, no interrupt output exists
  assign ch_led = led_r;

  // microsecond enable pulse from the clock
  // the prescaler wraps at US_CYC so each tick marks one microsecond
  assign us_tick = (pre_r == US_CYC - 1);

  always @(posedge clock) begin
    if (rst) begin
      pre_r <= 7'h00;
    end else if (us_tick) begin
      pre_r <= 7'h00;
    end else begin
      pre_r <= pre_r + 7'h01;
    end
  end

  // free running counter, wraps naturally at full scale
  // only reset clears it: the host sees the time since reset
  always @(posedge clock) begin
    if (rst) begin
      us_cnt_r <= 32'h00000000;
    end else if (us_tick) begin
      us_cnt_r <= us_cnt_r + 32'h00000001;
    end
  end

  // stamp taken when any fault condition newly appears
  // prev clears on reset so that faults present at release still stamp
  always @(posedge clock) begin
    if (rst) begin
      flt_prev_r <= {(4*NUM_CH+7){1'b0}};
      stamp_r <= 32'h00000000;
    end else begin
      flt_prev_r <= flt_now;
      if (new_flt) begin
        stamp_r <= us_cnt_r;
      end
    end
  end

  // channel indicators, registered so the pins do not glitch
  always @(posedge clock) begin
    if (rst) begin
      led_r <= {NUM_CH{1'b0}};
    end else begin
      led_r <= grp_err;
    end
  end

  // subindex offset into the record, only the low five bits are used
  assign sx_off = req_subindex - `AIDR_ECSUB_FIRST;

  // decode a request into start byte and length
  // unknown numbers give an error pulse instead of data
  always @* begin
    go = 1'b0;
    bad = 1'b0;
    start = 5'h00;
    len = `AIDR_REC_LEN;
    case (req_kind)
      `AIDR_KIND_RSET: begin
        if (req_number == `AIDR_RSET_FULL) begin
          go = 1'b1;
        end else if (req_number == `AIDR_RSET_HEAD) begin
          go = 1'b1;
          len = `AIDR_HEAD_LEN;
        end else begin
          bad = 1'b1;
        end
      end
      `AIDR_KIND_COIDX: begin
        if (req_number == `AIDR_COIDX_FULL) begin
          go = 1'b1;
        end else if (req_number == `AIDR_COIDX_HEAD) begin
          go = 1'b1;
          len = `AIDR_HEAD_LEN;
        end else begin
          bad = 1'b1;
        end
      end
      `AIDR_KIND_ECSUB: begin
        if (req_number != `AIDR_ECSUB_INDEX) begin
          bad = 1'b1;
        end else if (req_subindex >= `AIDR_ECSUB_FIRST &&
                     req_subindex <= `AIDR_ECSUB_LASTB) begin
          go = 1'b1;
          start = sx_off[4:0];
          len = 5'h01;
        end else if (req_subindex == `AIDR_ECSUB_STAMP) begin
          go = 1'b1;
          start = `AIDR_STAMP_POS;
          len = `AIDR_STAMP_LEN;
        end else begin
          bad = 1'b1;
        end
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // requests are taken only while idle
  // ready is combinational so a request can follow the last byte
  assign req_ready = (state_r == ST_IDLE);

  // answer sequencer, one record byte per clock
  // requests seen while busy are dropped; the host waits for ready
  always @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      idx_r <= 5'h00;
      left_r <= 5'h00;
      snap_r <= {(NB*8){1'b0}};
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_last <= 1'b0;
      rsp_err <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
      rsp_err <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (req_valid && bad) begin
            rsp_err <= 1'b1; // unknown number or subindex
          end else if (req_valid && go) begin
            snap_r <= live; // coherent copy of the record
            idx_r <= start;
            left_r <= len;
            state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          rsp_valid <= 1'b1;
          rsp_data <= snap_r[idx_r*8 +: 8];
          rsp_last <= (left_r == 5'h01);
          idx_r <= idx_r + 5'h01;
          left_r <= left_r - 5'h01;
          if (left_r == 5'h01) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // aidr_diag_record

// ==== verification/aidr_diag_record_monitor.sv ====
// assertion checker bound to the diagnostic record
`timescale 1ns/10ps
module aidr_diag_record_monitor (
  // clock and reset
  input wire clock,
  input wire rst,
  // request and answer
  input wire req_valid,
  input wire req_ready,
  input wire [1:0] req_kind,
  input wire [15:0] req_number,
  input wire [7:0] req_subindex,
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  input wire rsp_last,
  input wire rsp_err
);
  // taken requests split by access path
  wire tk = req_valid && req_ready;
  wire rs = tk && req_kind == 2'h0;
  wire co = tk && req_kind == 2'h1;
  wire ec = tk && req_kind == 2'h2 && req_number == 16'h5005;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_head_len:
    assert property (rs && req_number == 16'h0000 |->
    ##2 (rsp_valid && !rsp_last)[*3] ##1 rsp_last)
    else $error("short record has wrong length");
  a_full_len:
    assert property (rs && req_number == 16'h0001 |->
    ##2 rsp_valid ##19 rsp_last) else $error("full record wrong length");
  a_index_head:
    assert property (co && req_number == 16'h2F00 |-> ##5 rsp_last)
    else $error("index head read wrong length");
  a_fixed_bytes:
    assert property ((rs && req_number == 16'h0001) ||
    (co && req_number == 16'h2F01) |-> ##3 rsp_data == 8'h15
    ##1 rsp_data == 8'h00 ##2 rsp_data == 8'h71 ##1 rsp_data == 8'h08
    ##1 rsp_data == 8'h02) else $error("fixed record byte wrong");
  a_subindex_single:
    assert property (ec && req_subindex >= 8'h02 && req_subindex <= 8'h11
    |-> ##2 rsp_valid && rsp_last) else $error("subindex not one byte");
  a_bad_req:
    assert property (tk && (req_kind == 2'h3 || ec && req_subindex == 8'h12)
    |=> rsp_err && !rsp_valid) else $error("unknown request not refused");
  a_last_ready:
    assert property (rsp_last |-> rsp_valid && req_ready)
    else $error("last byte without ready");
  a_busy_answer:
    assert property (rsp_valid && !rsp_last |-> !req_ready)
    else $error("ready while answering");
  // main scenarios
  c_full: cover property (rs && req_number == 16'h0001);
  c_subindex: cover property (ec);
  c_err: cover property (rsp_err);
endmodule // aidr_diag_record_monitor

bind aidr_diag_record aidr_diag_record_monitor u_mon (.clock, .rst,
  .req_valid, .req_ready, .req_kind, .req_number, .req_subindex,
  .rsp_valid, .rsp_data, .rsp_last, .rsp_err);

// ==== verification/aidr_host_model.sv ====
// host side model that reads the diagnostic record
`timescale 1ns/10ps
module aidr_host_model (
  // bench control
  input wire clock,
  input wire go,
  input wire [25:0] cmd,
  output reg [4:0] n,
  output reg got_err,
  output reg done,
  // request and answer
  output reg req_valid,
  input wire req_ready,
  output reg [1:0] req_kind,
  output reg [15:0] req_number,
  output reg [7:0] req_subindex,
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  input wire rsp_last,
  input wire rsp_err
);
  reg [7:0] store_r [0:19];
  // idle values at time zero
  initial begin
    {n, got_err, done, req_valid} = 8'h00;
    {req_kind, req_number, req_subindex} = 26'h0;
  end
  // hold the request until taken, then gather the answer
  always @(posedge clock) begin
    if (go) begin
      req_valid <= 1'b1;
      {req_kind, req_number, req_subindex} <= cmd;
      n <= 5'h00;
      got_err <= 1'b0;
      done <= 1'b0;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      {req_number, req_subindex} <= ~{req_number, req_subindex};
    end
    if (rsp_valid) begin
      store_r[n] <= rsp_data;
      n <= n + 5'h01;
    end
    if (rsp_err)
      got_err <= 1'b1;
    if (rsp_err || rsp_last)
      done <= 1'b1;
  end
endmodule // aidr_host_model

// ==== verification/aidr_diag_record_tb.sv ====
// self-checking bench for the diagnostic record
`timescale 1ns/10ps
`include "aidr_consts.vh"
module aidr_diag_record_tb;
  localparam US = 2;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg go = 1'b0;
  reg [25:0] cmd = 26'h0;
  reg [14:0] f = 15'h0;
  wire req_valid, req_ready, rsp_valid, rsp_last, rsp_err, got_err, done;
  wire [1:0] req_kind, ch_led;
  wire [15:0] req_number;
  wire [7:0] req_subindex, rsp_data;
  wire [4:0] n;
  integer seed = 21;
  integer errors = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i, j, t0, r;
  // clock and cycles since reset
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= rst ? 0 : cyc + 1;
  aidr_diag_record #(.NUM_CH(2), .US_CYC(US)) DUT (.clock, .rst,
    .module_fail(f[0]), .internal_err(f[1]), .external_err(f[2]),
    .aux_supply_missing(f[3]), .param_err(f[4]), .diag_buf_overflow(f[5]),
    .comm_err(f[6]), .ch_param_err(f[8:7]), .ch_wire_break(f[10:9]),
    .ch_underflow(f[12:11]), .ch_overflow(f[14:13]), .ch_led, .req_valid,
    .req_ready, .req_kind, .req_number, .req_subindex, .rsp_valid,
    .rsp_data, .rsp_last, .rsp_err);
  aidr_host_model host (.clock, .go, .cmd, .n, .got_err, .done, .req_valid,
    .req_ready, .req_kind, .req_number, .req_subindex, .rsp_valid,
    .rsp_data, .rsp_last, .rsp_err);
  // expected record byte from the fault levels
  function [7:0] eb(input integer k);
    reg [1:0] g;
    begin
      g = f[8:7] | f[10:9] | f[12:11] | f[14:13];
      case (k)
        0: eb = {f[4] | (|f[8:7]), 2'h0, f[3], |g, f[2] | f[3],
          f[1] | f[5] | f[6], f[0]};
        1: eb = 8'h15;
        3: eb = {3'h0, f[6], f[5], 3'h0};
        4: eb = 8'h71;
        5: eb = 8'h08;
        6: eb = 8'h02;
        7: eb = {6'h0, g};
        8: eb = {f[13], f[11], 1'h0, f[9], 3'h0, f[7]};
        9: eb = {f[14], f[12], 1'h0, f[10], 3'h0, f[8]};
        default: eb = 8'h00;
      endcase
    end
  endfunction
  task check(input [39:0] nm, input [7:0] s, input [7:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("mismatch %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // one read through the host model, bounded wait
  task rd(input [25:0] c);
    integer k;
    begin
      @(posedge clock);
      go <= 1'b1;
      cmd <= c;
      @(posedge clock);
      go <= 1'b0;
      k = 0;
      @(posedge clock);
      #1;
      while (done !== 1'b1 && k < 40) begin
        @(posedge clock);
        #1;
        k = k + 1;
      end
      if (k == 40) begin
        errors = errors + 1;
        end_sim;
      end
    end
  endtask
  task cmp(input integer s, input integer c, input integer m);
    begin
      check("count", {3'h0, n}, c[7:0]);
      for (i = 0; i < m; i = i + 1)
        check("byte", host.store_r[i], eb(s + i));
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd({`AIDR_KIND_RSET, `AIDR_RSET_FULL, 8'h00});
    cmp(0, 20, 20);
    for (j = 0; j < 12; j = j + 1) begin
      r = $random(seed);
      @(posedge clock);
      f <= (j == 0) ? 15'h7FFF : r[14:0];
      repeat (3) @(posedge clock);
      #1;
      check("led", {6'h0, ch_led}, eb(7));
      if (j[0])
        rd({`AIDR_KIND_COIDX, `AIDR_COIDX_FULL, 8'h00});
      else
        rd({`AIDR_KIND_RSET, `AIDR_RSET_FULL, 8'h00});
      cmp(0, 20, 16);
    end
    rd({`AIDR_KIND_RSET, `AIDR_RSET_HEAD, 8'h00});
    cmp(0, 4, 4);
    rd({`AIDR_KIND_COIDX, `AIDR_COIDX_HEAD, 8'h00});
    cmp(0, 4, 4);
    for (j = 2; j < 18; j = j + 1) begin
      rd({`AIDR_KIND_ECSUB, `AIDR_ECSUB_INDEX, j[7:0]});
      cmp(j - 2, 1, 1);
    end
    @(posedge clock);
    f <= 15'h0000;
    repeat (6) @(posedge clock);
    t0 = cyc;
    f <= 15'h0001;
    repeat (6) @(posedge clock);
    rd({`AIDR_KIND_ECSUB, `AIDR_ECSUB_INDEX, `AIDR_ECSUB_STAMP});
    r = {host.store_r[0], host.store_r[1], host.store_r[2],
      host.store_r[3]} - t0 / US;
    check("count", {3'h0, n}, 8'h04);
    check("stamp", {7'h0, r >= -2 && r <= 2}, 8'h01);
    for (j = 0; j < 3; j = j + 1) begin
      if (j == 0)
        rd({`AIDR_KIND_ECSUB, `AIDR_ECSUB_INDEX, 8'h12});
      else if (j == 1)
        rd({2'h3, `AIDR_RSET_FULL, 8'h00});
      else
        rd({`AIDR_KIND_RSET, 16'h0002, 8'h00});
      check("err", {7'h0, got_err}, 8'h01);
      check("count", {3'h0, n}, 8'h00);
    end
    end_sim;
  end
endmodule // aidr_diag_record_tb
